/* shared/slcm_pkg.sv */
// Constants, register map and field layout of the sensor line mode control
// Function
// - Pin mode: style low/low high-side, low/high low-side, select high push-pull.
// - Pin mode: receiver and sense on, filter on, pulls off, no retry, 128us blanking.
// - Multiplexed, mux_select_mode 0: style select low is register phase, high is UART.
// - Multiplexed, mux_select_mode 1: uart_mux_select picks phase; pins latched on its fall.
// - Fault interrupt output stays active during UART phases of both multiplexed modes.
// - Transmit pins high let line and aux state bits drive, gated by disables.
// - A set driver disable bit puts that driver in high impedance.
// - Pin mode: line driver on only with transmit enable, level is inverse of transmit.
// - Pin mode: current limit is 100mA with limit pin low, 200mA with it high.
// - Register mode: current limit from two-bit field, 50, 100, 200 or 250mA.
// - Fault only after overcurrent lasts past blanking time; blanking set by register in register mode.
// - Pin mode: active-low fault output low while either driver has a short.
// - Register mode: fault sets status and interrupt bits and asserts interrupt output.
// - Short keeps sourcing current, or with auto-retry disables after blanking then re-enables.
// - Receive output is inverse of sensed line; receiver always on in pin mode.
// - Register mode: rx_disable floats receive output; line level status then invalid.
// - Multiplexed: shared pin carries receiver, floats with style select high and rx_disable.
// - Pin mode: aux driver always enabled, level is inverse of aux_output_in.
// - Interrupt bits clear only on interrupt register read; status follows the fault.
// - Register mode: line_aux_track makes aux driver follow line driver.
package slcm_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] LINE_CONFIG_OFS   = 8'h00;
    localparam logic [7:0] AUX_CONFIG_OFS    = 8'h04;
    localparam logic [7:0] CURRENT_LIMIT_OFS = 8'h08;
    localparam logic [7:0] MODE_OFS          = 8'h0c;
    localparam logic [7:0] STATUS_OFS        = 8'h10;
    localparam logic [7:0] INTERRUPT_OFS     = 8'h14;

    // ==========================================================
    // Field positions
    localparam int DRV_STATE_BIT  = 0;
    localparam int DRV_DIS_BIT    = 1;
    localparam int STYLE_LSB      = 2;
    localparam int SENSE_DIS_BIT  = 4;
    localparam int WEAK_PULL_BIT  = 5;
    localparam int TRACK_BIT      = 6;
    localparam int FILTER_BIT     = 7;
    localparam int LIMIT_LSB      = 0;
    localparam int BLANK_LSB      = 2;
    localparam int RETRY_BIT      = 4;
    localparam int MUX_MODE_BIT   = 0;
    localparam int LVL_BIT        = 0;
    localparam int LINE_FAULT_BIT = 1;
    localparam int AUX_FAULT_BIT  = 2;
    localparam int AUX_LVL_BIT    = 3;

    // ==========================================================
    // Reset values
    localparam logic [7:0] LINE_CONFIG_RST   = 8'h82;
    localparam logic [7:0] AUX_CONFIG_RST    = 8'h02;
    localparam logic [7:0] CURRENT_LIMIT_RST = 8'h0d;
    localparam logic [7:0] MODE_RST          = 8'h00;

    // ==========================================================
    // Drive styles and current limit codes
    typedef enum logic [1:0] {
        STYLE_HIGH_SIDE = 2'b00,
        STYLE_LOW_SIDE  = 2'b01,
        STYLE_PUSH_PULL = 2'b10
    } slcm_style_e;
    localparam logic [1:0] LIMIT_100MA = 2'h1;
    localparam logic [1:0] LIMIT_200MA = 2'h2;

    // ==========================================================
    // Synchronised pin indices
    localparam int PIN_IFACE  = 0;
    localparam int PIN_STYLE  = 1;
    localparam int PIN_SDATA  = 2;
    localparam int PIN_LIMIT  = 3;
    localparam int PIN_UMUX   = 4;
    localparam int PIN_TRANSMIT_DRIVE_ENABLE   = 5;
    localparam int PIN_TX     = 6;
    localparam int PIN_AUXIN  = 7;
    localparam int PIN_SENSE  = 8;
    localparam int PIN_AUXSNS = 9;
    localparam int PIN_COUNT  = 10;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ      = 20;
    localparam int BLANK_PIN_US = 128;
    localparam int BLANK0_US    = 16;
    localparam int BLANK1_US    = 32;
    localparam int BLANK2_US    = 64;
    localparam int RETRY_OFF_US = 16;
    localparam int CNT_W        = 12;
    localparam logic [CNT_W-1:0] BLANK_PIN_CYC = CNT_W'(BLANK_PIN_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] BLANK0_CYC    = CNT_W'(BLANK0_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] BLANK1_CYC    = CNT_W'(BLANK1_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] BLANK2_CYC    = CNT_W'(BLANK2_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] RETRY_OFF_CYC = CNT_W'(RETRY_OFF_US * CLK_MHZ);

endpackage

/* core/slcm_ctrl.sv */
// Mode control, driver steering, fault detection and APB registers
module slcm_ctrl
    import slcm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins from the controller
    input  wire logic        interface_select,
    input  wire logic        drive_style_sel,
    input  wire logic        style_data_in,
    input  wire logic        limit_sel_pin,
    input  wire logic        uart_mux_select,
    input  wire logic        transmit_drive_enable,
    input  wire logic        transmit_in,
    input  wire logic        aux_output_in,
    // Analog front end
    input  wire logic        line_sense,
    input  wire logic        aux_sense_input,
    input  wire logic        line_overcurrent,
    input  wire logic        aux_overcurrent,
    // Driver controls
    output logic             line_pull_up,
    output logic             line_pull_down,
    output logic             aux_pull_up,
    output logic             aux_pull_down,
    output logic [1:0]       current_limit_code,
    output logic             rx_filter_en,
    output logic             aux_sense_en,
    output logic             line_weak_pull_en,
    output logic             aux_weak_pull_en,
    // Logic outputs
    output logic             receive_out,
    output logic             receive_oe_n,
    output logic             shared_serial_out,
    output logic             shared_serial_oe_n,
    output logic             fault_irq_out_n
);

    // ==========================================================
    // Pin synchronisers
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_meta_r;
    logic [PIN_COUNT-1:0] pin_r;

    assign pin_raw = {aux_sense_input, line_sense, aux_output_in, transmit_in,
                      transmit_drive_enable, uart_mux_select, limit_sel_pin,
                      style_data_in, drive_style_sel, interface_select};

    genvar gp;
    generate
        for (gp = 0; gp < PIN_COUNT; gp++) begin : g_sync
            always_ff @(posedge clk) begin
                if (rst) begin
                    pin_meta_r[gp] <= 1'b0;
                    pin_r[gp]      <= 1'b0;
                end else begin
                    pin_meta_r[gp] <= pin_raw[gp];
                    pin_r[gp]      <= pin_meta_r[gp];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Registers
    logic [7:0] line_config_r;
    logic [7:0] aux_config_r;
    logic [7:0] current_limit_r;
    logic [7:0] mode_r;
    logic [1:0] irq_r;
    logic [1:0] fault_act;
    logic [1:0] fault_act_d_r;
    logic       wr_en;
    logic       rd_irq;
    logic       mapped;

    assign wr_en  = psel & penable & pwrite;
    assign rd_irq = psel & penable & ~pwrite & (paddr == INTERRUPT_OFS);
    assign pready = 1'b1;
    assign mapped = (paddr == LINE_CONFIG_OFS) | (paddr == AUX_CONFIG_OFS)
                  | (paddr == CURRENT_LIMIT_OFS) | (paddr == MODE_OFS)
                  | (paddr == STATUS_OFS) | (paddr == INTERRUPT_OFS);
    assign pslverr = psel & penable & ~mapped;

    always_ff @(posedge clk) begin
        if (rst) begin
            line_config_r   <= LINE_CONFIG_RST;
            aux_config_r    <= AUX_CONFIG_RST;
            current_limit_r <= CURRENT_LIMIT_RST;
            mode_r          <= MODE_RST;
        end else if (wr_en) begin
            if (paddr == LINE_CONFIG_OFS)
                line_config_r <= pwdata[7:0];
            if (paddr == AUX_CONFIG_OFS)
                aux_config_r <= pwdata[7:0];
            if (paddr == CURRENT_LIMIT_OFS)
                current_limit_r <= pwdata[7:0];
            if (paddr == MODE_OFS)
                mode_r <= pwdata[7:0];
        end
    end

    // Sticky fault interrupts; a new fault wins over the read clear
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_r         <= 2'h0;
            fault_act_d_r <= 2'h0;
        end else begin
            fault_act_d_r <= fault_act;
            irq_r         <= (rd_irq ? 2'h0 : irq_r)
                           | (fault_act & ~fault_act_d_r);
        end
    end

    // ==========================================================
    // Mode decode
    logic reg_mode;
    logic mux_active;
    logic uart_phase;
    logic uart_phase_d_r;
    logic tx_en_hold_r;
    logic tx_hold_r;
    logic tx_en;
    logic tx;

    assign reg_mode   = pin_r[PIN_IFACE];
    assign mux_active = reg_mode & (mode_r[MUX_MODE_BIT] | pin_r[PIN_UMUX]);
    assign uart_phase = mode_r[MUX_MODE_BIT] ? pin_r[PIN_UMUX]
                                             : pin_r[PIN_STYLE];

    // Shared transmit pins latched when the UART phase ends
    always_ff @(posedge clk) begin
        if (rst) begin
            uart_phase_d_r <= 1'b0;
            tx_en_hold_r   <= 1'b0;
            tx_hold_r      <= 1'b1;
        end else begin
            uart_phase_d_r <= uart_phase;
            if (mux_active & uart_phase_d_r & ~uart_phase) begin
                tx_en_hold_r <= pin_r[PIN_LIMIT];
                tx_hold_r    <= pin_r[PIN_SDATA];
            end
        end
    end

    always_comb begin
        if (!mux_active) begin
            tx_en = pin_r[PIN_TRANSMIT_DRIVE_ENABLE];
            tx    = pin_r[PIN_TX];
        end else if (uart_phase | uart_phase_d_r) begin
            // Falling cycle uses the value being latched, so no glitch
            tx_en = pin_r[PIN_LIMIT];
            tx    = pin_r[PIN_SDATA];
        end else begin
            tx_en = tx_en_hold_r;
            tx    = tx_hold_r;
        end
    end

    // ==========================================================
    // Styles, retry and blanking selection
    logic [1:0]       line_style;
    logic [1:0]       aux_style;
    logic [1:0]       pin_style;
    logic [CNT_W-1:0] blank_cyc;
    logic             retry_en;

    always_comb begin
        if (pin_r[PIN_STYLE])
            pin_style = STYLE_PUSH_PULL;
        else if (pin_r[PIN_SDATA])
            pin_style = STYLE_LOW_SIDE;
        else
            pin_style = STYLE_HIGH_SIDE;
    end

    assign line_style = reg_mode ? line_config_r[STYLE_LSB+:2] : pin_style;
    assign aux_style  = reg_mode ? aux_config_r[STYLE_LSB+:2] : pin_style;
    assign retry_en   = reg_mode & current_limit_r[RETRY_BIT];

    always_comb begin
        if (!reg_mode)
            blank_cyc = BLANK_PIN_CYC;
        else begin
            unique case (current_limit_r[BLANK_LSB+:2])
                2'h0: blank_cyc = BLANK0_CYC;
                2'h1: blank_cyc = BLANK1_CYC;
                2'h2: blank_cyc = BLANK2_CYC;
                2'h3: blank_cyc = BLANK_PIN_CYC;
            endcase
        end
    end

    // ==========================================================
    // Driver intent before fault handling
    logic [1:0] drv_on;
    logic [1:0] drv_lvl;
    logic [1:0] drv_style [2];
    logic       line_state;
    logic       line_on;
    logic       line_lvl;
    logic       aux_state;

    assign line_state = reg_mode & line_config_r[DRV_STATE_BIT];
    assign aux_state  = reg_mode & aux_config_r[DRV_STATE_BIT];
    assign line_on    = (tx_en | line_state)
                      & ~(reg_mode & line_config_r[DRV_DIS_BIT]);
    assign line_lvl   = line_state | ~tx;

    always_comb begin
        drv_on[0]    = line_on;
        drv_lvl[0]   = line_lvl;
        drv_style[0] = line_style;
        drv_style[1] = aux_style;
        if (reg_mode & aux_config_r[DRV_DIS_BIT]) begin
            drv_on[1]  = 1'b0;
            drv_lvl[1] = 1'b0;
        end else if (reg_mode & line_config_r[TRACK_BIT]) begin
            drv_on[1]  = (tx_en | line_state);
            drv_lvl[1] = line_lvl;
        end else begin
            drv_on[1]  = 1'b1;
            drv_lvl[1] = aux_state | ~pin_r[PIN_AUXIN];
        end
    end

    // ==========================================================
    // Per driver blanking, fault and auto-retry
    logic [1:0] oc_meta_r;
    logic [1:0] oc_r;
    logic [1:0] retry_off_r;
    logic [1:0] pull_up_r;
    logic [1:0] pull_down_r;

    genvar gd;
    generate
        for (gd = 0; gd < 2; gd++) begin : g_drv
            logic [CNT_W-1:0] blank_cnt_r;
            logic [CNT_W-1:0] off_cnt_r;
            logic             oc_in;

            assign oc_in = (gd == 0) ? line_overcurrent : aux_overcurrent;

            always_ff @(posedge clk) begin
                if (rst) begin
                    oc_meta_r[gd] <= 1'b0;
                    oc_r[gd]      <= 1'b0;
                end else begin
                    oc_meta_r[gd] <= oc_in;
                    oc_r[gd]      <= oc_meta_r[gd];
                end
            end

            // Overcurrent must persist past blanking before it is a fault
            always_ff @(posedge clk) begin
                if (rst) begin
                    blank_cnt_r   <= '0;
                    fault_act[gd] <= 1'b0;
                end else if (!oc_r[gd] || retry_off_r[gd]) begin
                    blank_cnt_r   <= '0;
                    fault_act[gd] <= retry_off_r[gd] & fault_act[gd];
                end else if (blank_cnt_r >= blank_cyc) begin
                    fault_act[gd] <= 1'b1;
                end else begin
                    blank_cnt_r <= blank_cnt_r + 1'b1;
                end
            end

            // Auto-retry switches the driver off, then back on
            always_ff @(posedge clk) begin
                if (rst) begin
                    retry_off_r[gd] <= 1'b0;
                    off_cnt_r       <= '0;
                end else if (retry_off_r[gd]) begin
                    if (off_cnt_r >= RETRY_OFF_CYC - 1'b1) begin
                        retry_off_r[gd] <= 1'b0;
                        off_cnt_r       <= '0;
                    end else begin
                        off_cnt_r <= off_cnt_r + 1'b1;
                    end
                end else if (retry_en && oc_r[gd] && blank_cnt_r >= blank_cyc) begin
                    retry_off_r[gd] <= 1'b1;
                end
            end

            // Registered drive per style
            always_ff @(posedge clk) begin
                if (rst) begin
                    pull_up_r[gd]   <= 1'b0;
                    pull_down_r[gd] <= 1'b0;
                end else begin
                    pull_up_r[gd]   <= drv_on[gd] & ~retry_off_r[gd] & drv_lvl[gd]
                                     & (drv_style[gd] != STYLE_LOW_SIDE);
                    pull_down_r[gd] <= drv_on[gd] & ~retry_off_r[gd] & ~drv_lvl[gd]
                                     & (drv_style[gd] != STYLE_HIGH_SIDE);
                end
            end
        end
    endgenerate

    assign line_pull_up   = pull_up_r[0];
    assign line_pull_down = pull_down_r[0];
    assign aux_pull_up    = pull_up_r[1];
    assign aux_pull_down  = pull_down_r[1];

    // ==========================================================
    // Receiver, configuration and fault outputs
    logic rx_dis;

    assign rx_dis = reg_mode & line_config_r[SENSE_DIS_BIT];

    always_ff @(posedge clk) begin
        if (rst) begin
            current_limit_code <= LIMIT_100MA;
            rx_filter_en       <= 1'b1;
            aux_sense_en       <= 1'b1;
            line_weak_pull_en  <= 1'b0;
            aux_weak_pull_en   <= 1'b0;
            receive_out        <= 1'b1;
            receive_oe_n       <= 1'b0;
            shared_serial_out  <= 1'b1;
            shared_serial_oe_n <= 1'b1;
            fault_irq_out_n    <= 1'b1;
        end else begin
            current_limit_code <= reg_mode ? current_limit_r[LIMIT_LSB+:2]
                                : (pin_r[PIN_LIMIT] ? LIMIT_200MA : LIMIT_100MA);
            rx_filter_en       <= ~reg_mode | line_config_r[FILTER_BIT];
            aux_sense_en       <= ~reg_mode | ~aux_config_r[SENSE_DIS_BIT];
            line_weak_pull_en  <= reg_mode & line_config_r[WEAK_PULL_BIT];
            aux_weak_pull_en   <= reg_mode & aux_config_r[WEAK_PULL_BIT];
            receive_out        <= ~pin_r[PIN_SENSE];
            receive_oe_n       <= rx_dis;
            shared_serial_out  <= ~pin_r[PIN_SENSE];
            shared_serial_oe_n <= ~mux_active | (pin_r[PIN_STYLE] & rx_dis);
            fault_irq_out_n    <= reg_mode ? ~(|irq_r)
                                           : ~(|fault_act);
        end
    end

    // ==========================================================
    // Read data
    logic [7:0] status_val;

    always_comb begin
        status_val                 = 8'h00;
        status_val[LVL_BIT]        = ~rx_dis & pin_r[PIN_SENSE];
        status_val[LINE_FAULT_BIT] = fault_act[0];
        status_val[AUX_FAULT_BIT]  = fault_act[1];
        status_val[AUX_LVL_BIT]    = pin_r[PIN_AUXSNS];
    end

    always_comb begin
        prdata = 32'h0;
        if (psel & ~pwrite) begin
            unique case (paddr)
                LINE_CONFIG_OFS:   prdata = {24'h0, line_config_r};
                AUX_CONFIG_OFS:    prdata = {24'h0, aux_config_r};
                CURRENT_LIMIT_OFS: prdata = {24'h0, current_limit_r};
                MODE_OFS:          prdata = {24'h0, mode_r};
                STATUS_OFS:        prdata = {24'h0, status_val};
                INTERRUPT_OFS:     prdata = {30'h0, irq_r};
                default:           prdata = 32'h0;
            endcase
        end
    end

endmodule

/* dv/slcm_line_model.sv */
// Behavioural line and load model beyond the drivers
module slcm_line_model (
    input  wire logic line_pull_up,
    input  wire logic line_pull_down,
    input  wire logic short_line,
    output logic      line_sense,
    output logic      aux_sense_input,
    output logic      line_overcurrent,
    output logic      aux_overcurrent
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Line load
    // Weak load to ground: a released line reads low
    assign line_sense       = line_pull_up & ~line_pull_down;
    assign aux_sense_input  = ~line_sense;
    // Short to ground draws excess current only while driven high
    assign line_overcurrent = short_line & line_pull_up;
    assign aux_overcurrent  = 1'b0;
endmodule

/* dv/slcm_ctrl_asserts.sv */
// Checker of pin-mode steering and fault timing
module slcm_ctrl_asserts
    import slcm_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       interface_select,
    input wire logic       drive_style_sel,
    input wire logic       style_data_in,
    input wire logic       limit_sel_pin,
    input wire logic       transmit_drive_enable,
    input wire logic       transmit_in,
    input wire logic       aux_output_in,
    input wire logic       line_overcurrent,
    input wire logic       aux_overcurrent,
    input wire logic       line_pull_up,
    input wire logic       line_pull_down,
    input wire logic       aux_pull_up,
    input wire logic       aux_pull_down,
    input wire logic [1:0] current_limit_code,
    input wire logic       rx_filter_en,
    input wire logic       aux_sense_en,
    input wire logic       line_weak_pull_en,
    input wire logic       aux_weak_pull_en,
    input wire logic       receive_oe_n,
    input wire logic       fault_irq_out_n
);
    // ==========================================================
    // Overcurrent run length
    logic [CNT_W-1:0] oc_run_r;
    always_ff @(posedge clk) begin
        if (rst || !(line_overcurrent || aux_overcurrent))
            oc_run_r <= '0;
        else if (oc_run_r != '1)
            oc_run_r <= oc_run_r + 1'b1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Properties
    a_pin_drive_off: assert property ((!interface_select && !transmit_drive_enable)[*5]
        |-> !line_pull_up && !line_pull_down) else $error("line driven without enable");
    a_pin_push_high: assert property ((!interface_select && drive_style_sel
        && transmit_drive_enable && !transmit_in)[*5] |-> line_pull_up && !line_pull_down)
        else $error("push-pull line not driven high");
    a_pin_low_side: assert property ((!interface_select && !drive_style_sel && style_data_in)[*5]
        |-> !line_pull_up && !aux_pull_up) else $error("low-side driver pulled up");
    a_pin_limit_sel: assert property ((!interface_select && limit_sel_pin)[*5]
        |-> current_limit_code == LIMIT_200MA) else $error("pin limit not 200mA");
    a_pin_fixed_cfg: assert property (!interface_select[*5] |-> rx_filter_en && aux_sense_en
        && !line_weak_pull_en && !aux_weak_pull_en && !receive_oe_n) else $error("pin config");
    a_pin_aux_inv: assert property ((!interface_select && drive_style_sel && !aux_output_in)[*5]
        |-> aux_pull_up && !aux_pull_down) else $error("aux not inverse of input");
    a_fault_not_early: assert property (!interface_select
        && oc_run_r inside {[12'd8 : BLANK_PIN_CYC - 12'd8]} |-> fault_irq_out_n)
        else $error("fault before blanking ends");
    a_fault_pin_out: assert property (!interface_select
        && oc_run_r == BLANK_PIN_CYC + 12'd8 |-> !fault_irq_out_n) else $error("fault missing");
endmodule
bind slcm_ctrl slcm_ctrl_asserts slcm_ctrl_asserts_i (.*);

/* dv/tb.sv */
// Self-checking bench of the sensor line mode control block
module tb
    import slcm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err, h, l, up;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, interface_select = 0, drive_style_sel = 0, style_data_in = 0;
    logic limit_sel_pin = 0, uart_mux_select = 0, transmit_drive_enable = 0, transmit_in = 0;
    logic aux_output_in = 0, short_line = 0, line_sense, aux_sense_input;
    logic line_overcurrent, aux_overcurrent, line_pull_up, line_pull_down, aux_pull_up;
    logic aux_pull_down, rx_filter_en, aux_sense_en, line_weak_pull_en, aux_weak_pull_en;
    logic receive_out, receive_oe_n, shared_serial_out, shared_serial_oe_n, fault_irq_out_n;
    logic [1:0] current_limit_code;
    logic [7:0] cfg[3] = '{8'h09, 8'h0b, 8'h08};
    logic [1:0] drv[3] = '{2'b10, 2'b00, 2'b01};
    int miscompares = 0, comparisons = 0;
    slcm_ctrl slcm_ctrl_i (.*);
    slcm_line_model slcm_line_model_i (.*);
    always #25 clk = ~clk;
    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        {err, rd} = {pslverr, prdata};
        {psel, penable} <= 2'b00;
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            {limit_sel_pin, aux_output_in, transmit_in, transmit_drive_enable, style_data_in,
                drive_style_sel} <= {i[4:3], i[3:0]};
            repeat (7) @(posedge clk);
            h = i[0] | ~i[1];
            l = i[0] | i[1];
            up = i[2] & ~i[3] & h;
            chk({line_pull_up, line_pull_down, aux_pull_up, aux_pull_down, receive_out},
                {up, i[2] & i[3] & l, ~i[3] & h, i[3] & l, ~up});
            chk(current_limit_code, i[4] ? LIMIT_200MA : LIMIT_100MA);
            chk({rx_filter_en, aux_sense_en, line_weak_pull_en, aux_weak_pull_en}, 4'hc);
        end
        @(posedge clk);
        {drive_style_sel, transmit_drive_enable, transmit_in, short_line} <= 4'b1101;
        repeat (BLANK_PIN_CYC - 12'd20) @(posedge clk);
        chk(fault_irq_out_n, 1'b1);
        repeat (40) @(posedge clk);
        chk(fault_irq_out_n, 1'b0);
        short_line <= 1'b0;
        repeat (10) @(posedge clk);
        chk(fault_irq_out_n, 1'b1);
        {interface_select, transmit_drive_enable, transmit_in, aux_output_in} <= 4'hf;
        apb(0, CURRENT_LIMIT_OFS, 32'h0);
        chk(rd, CURRENT_LIMIT_RST);
        apb(0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        for (int k = 0; k < 4; k++) begin
            apb(1, CURRENT_LIMIT_OFS, k);
            repeat (4) @(posedge clk);
            chk(current_limit_code, k[1:0]);
        end
        foreach (cfg[k]) begin
            apb(1, LINE_CONFIG_OFS, {24'h0, cfg[k] | 8'h80});
            apb(1, AUX_CONFIG_OFS, {24'h0, cfg[k]});
            repeat (4) @(posedge clk);
            chk({line_pull_up, line_pull_down, aux_pull_up, aux_pull_down}, {drv[k], drv[k]});
        end
        apb(1, LINE_CONFIG_OFS, 32'h89);
        short_line <= 1'b1;
        repeat (BLANK0_CYC + 12'd20) @(posedge clk);
        apb(0, STATUS_OFS, 32'h0);
        chk({rd[7:0], fault_irq_out_n}, 9'h006);
        short_line <= 1'b0;
        repeat (10) @(posedge clk);
        apb(0, STATUS_OFS, 32'h0);
        chk({rd[7:0], fault_irq_out_n}, 9'h002);
        apb(0, INTERRUPT_OFS, 32'h0);
        chk(rd, 32'h1);
        repeat (2) @(posedge clk);
        chk(fault_irq_out_n, 1'b1);
        apb(1, CURRENT_LIMIT_OFS, 32'h13);
        short_line <= 1'b1;
        repeat (BLANK0_CYC + 12'd20) @(posedge clk);
        chk(line_pull_up, 1'b0);
        repeat (RETRY_OFF_CYC) @(posedge clk);
        chk(line_pull_up, 1'b1);
        short_line <= 1'b0;
        {transmit_drive_enable, transmit_in, limit_sel_pin, style_data_in} <= 4'b0101;
        apb(1, MODE_OFS, 32'h1);
        apb(1, LINE_CONFIG_OFS, 32'h99);
        repeat (4) @(posedge clk);
        chk({receive_oe_n, shared_serial_oe_n, shared_serial_out}, 3'b110);
        apb(1, LINE_CONFIG_OFS, 32'h89);
        repeat (4) @(posedge clk);
        chk({receive_oe_n, shared_serial_oe_n}, 2'b00);
        apb(1, LINE_CONFIG_OFS, 32'h88);
        {uart_mux_select, limit_sel_pin, style_data_in} <= 3'b110;
        repeat (6) @(posedge clk);
        chk({line_pull_up, line_pull_down, fault_irq_out_n}, 3'b100);
        uart_mux_select <= 1'b0;
        repeat (6) @(posedge clk);
        {limit_sel_pin, style_data_in} <= 2'b01;
        repeat (6) @(posedge clk);
        chk({line_pull_up, line_pull_down}, 2'b10);
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
endmodule
